// >>> hdl/ec_regs_cfg.svh
// offsets, field positions, reset values and timing for the register bank
`ifndef EC_REGS_CFG_SVH
`define EC_REGS_CFG_SVH

`define EC_PAGE 8'h7F
`define OFF_REV 8'h06
`define OFF_DEV_ID 8'h07
`define OFF_LED 8'h21
`define OFF_PORT_D 8'h22
`define OFF_PORT_E 8'h23
`define OFF_PORT_F 8'h24
`define OFF_PW0 8'h25
`define OFF_PW1 8'h26
`define OFF_CLK_CTL 8'h27
`define OFF_MEM_MAP 8'h29
`define OFF_WSRC1 8'h2A
`define OFF_WSRC2 8'h2B
`define OFF_WMASK1 8'h2C
`define OFF_WMASK2 8'h2D
`define OFF_PSEL3 8'h30
`define OFF_TW_CTL_STAT 8'h31
`define OFF_TW_ADDR 8'h32
`define OFF_TW_DATA 8'h33
`define OFF_TW_CLK 8'h34
`define OFF_WSRC3 8'h35
`define OFF_WMASK3 8'h36
`define OFF_WDT_CTL 8'h37
`define OFF_WDT_CNT 8'h38
`define OFF_PP_STAT 8'h3A
`define OFF_PP_CTL 8'h3B
`define OFF_PP_DATA 8'h3C
`define OFF_PSEL1 8'h3D
`define OFF_OUT_EN 8'h3E
`define OFF_DISABLE 8'h3F
`define OFF_PSEL2 8'h40
`define OFF_PS2A_CTL 8'h41
`define OFF_PS2A_STAT 8'h42
`define OFF_PS2A_ERR 8'h43
`define OFF_PS2A_TX 8'h44
`define OFF_PS2A_RX 8'h45
`define OFF_PS2B_CTL 8'h49
`define OFF_PS2B_STAT 8'h4A
`define OFF_PS2B_ERR 8'h4B
`define OFF_PS2B_TX 8'h4C
`define OFF_PS2B_RX 8'h4D
`define OFF_KBD_DATA 8'hF1
`define OFF_KBD_STAT 8'hF2
`define OFF_KBD_CFG 8'hF4
`define OFF_KBD_AUX 8'hFA
`define IDX_PW0 8'h92
`define IDX_PW1 8'h93

`define CFG_AUX_HW_BIT 7
`define CFG_OBF_EN_BIT 5
`define ST_PRI_FULL 0
`define ST_IN_FULL 1
`define ST_CMD 3
`define ST_AUX_FULL 5
`define ST_FW_MASK 8'hD4
`define OE_PG_BIT 2
`define OE_IRO_BIT 1
`define OE_OVRD_BIT 3
`define OE_WR_MASK 8'h0B
`define PP_STAT_WR_MASK 8'h01

`define RST_CLK_CTL 8'h10
`define RST_WMASK3 8'hFF
`define RST_WDT_CNT 8'hFF
`define RST_OUT_EN_SB 8'h02
`define RST_PORT_D 8'hFF
`define RST_PORT_E 8'h0F

`define CLK_MHZ 250
`define MAIN_LONG_US 500
`define MAIN_SHORT_US 10
`define MAIN_SHORT_CYC (`MAIN_SHORT_US * `CLK_MHZ)

`endif

// >>> hdl/ec_regs_pkg.sv
// types shared by the embedded controller register bank
package ec_regs_pkg;

  typedef enum logic [1:0] {
    MP_OFF = 2'h0,
    MP_WAIT = 2'h1,
    MP_ON = 2'h3
  } main_seq_e;

  typedef struct packed {
    logic [7:0] led;
    logic [7:0] port_d;
    logic [7:0] port_e;
    logic [7:0] pw0;
    logic [7:0] pw1;
    logic [7:0] clk_ctl;
    logic [7:0] mem_map;
    logic [7:0] wmask1;
    logic [7:0] wmask2;
    logic [7:0] wmask3;
    logic [7:0] psel1;
    logic [7:0] psel2;
    logic [7:0] psel3;
    logic [7:0] tw_ctl;
    logic [7:0] tw_addr;
    logic [7:0] tw_data;
    logic [7:0] tw_clk;
    logic [7:0] wdt_ctl;
    logic [7:0] wdt_cnt;
    logic [7:0] pp_stat;
    logic [7:0] pp_ctl;
    logic [7:0] pp_data;
    logic [7:0] out_en;
    logic [7:0] func_dis;
    logic [7:0] ps2a_ctl;
    logic [7:0] ps2a_tx;
    logic [7:0] ps2b_ctl;
    logic [7:0] ps2b_tx;
    logic [7:0] kbd_cfg;
  } ctrl_regs_s;

  typedef struct packed {
    logic [7:0] port_f;
    logic [7:0] wsrc1;
    logic [7:0] wsrc2;
    logic [7:0] wsrc3;
    logic [7:0] tw_stat;
    logic [7:0] ps2a_stat;
    logic [7:0] ps2a_err;
    logic [7:0] ps2a_rx;
    logic [7:0] ps2b_stat;
    logic [7:0] ps2b_err;
    logic [7:0] ps2b_rx;
  } periph_stat_s;

  typedef struct packed {
    ctrl_regs_s ctl;
    logic [7:0] out_data;
    logic [7:0] in_data;
    logic [7:0] kbd_stat;
    logic [7:0] xrdata;
    logic [7:0] sys_rdata;
    main_seq_e seq;
    logic [16:0] cnt;
  } bank_state_s;

endpackage : ec_regs_pkg

// >>> hdl/embedded_controller_register_map.sv
// register bank of the embedded keyboard/system controller
// Operation
// - registers live at page 7F00 plus offset
// - in and out data share one address
// - firmware cannot write hardware status bits
// - aux write loads data, sets aux flag only
// - firmware read clears its pending interrupt
// - host read clears its pending interrupt
// - system access to pulse width: zero wait
// - parallel status: only bit 0 writable
// - clearing reset-out sets stop-clock and memory bits
// - output enable resets 00000X10 / 00000X1X
// - normal clock and valid time: 500us delay
// - otherwise main-plane reset within 10us
// - port D/E get defaults at main reset
// - hardwired revision register readable
// - aux hardware bit makes aux flag hardware-set
// - reset-out uncleared while power good low
`timescale 1ns/1ps
`include "ec_regs_cfg.svh"

module embedded_controller_register_map
  import ec_regs_pkg::*;
#(
  parameter int unsigned MAIN_LONG_CYC = `MAIN_LONG_US * `CLK_MHZ,
  parameter logic [7:0] REV_CODE = 8'h01, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h5A // arbitrary value
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [15:0] xaddr_i,
  input wire logic xrd_i,
  input wire logic xwr_i,
  input wire logic [7:0] xwdata_i,
  output logic [7:0] xrdata_o,
  input wire logic [7:0] sys_index_i,
  input wire logic sys_rd_i,
  input wire logic sys_wr_i,
  input wire logic [7:0] sys_wdata_i,
  output logic [7:0] sys_rdata_o,
  output logic zero_wait_o,
  input wire logic host_wr_i,
  input wire logic host_cmd_i,
  input wire logic [7:0] host_wdata_i,
  input wire logic host_rd_i,
  output logic [7:0] host_rdata_o,
  output logic [7:0] host_status_o,
  output logic kbd_irq_o,
  output logic aux_irq_o,
  input wire logic main_valid_i,
  input wire logic power_good_input_i,
  input wire logic clock_normal_mode_i,
  input wire logic clock_valid_time_bit_i,
  input wire periph_stat_s periph_i,
  output ctrl_regs_s regs_o,
  output logic main_plane_ready_o
);

  localparam ctrl_regs_s CTL_INIT = '{
    clk_ctl: `RST_CLK_CTL,
    wmask3: `RST_WMASK3,
    wdt_cnt: `RST_WDT_CNT,
    out_en: `RST_OUT_EN_SB,
    default: 8'h00
  };
  localparam logic [16:0] LONG_LAST = 17'(MAIN_LONG_CYC - 1);
  localparam logic [16:0] SHORT_LAST = 17'(`MAIN_SHORT_CYC - 1);

  bank_state_s s_q;
  bank_state_s s_d;
  logic fw_hit;
  logic [7:0] off;
  logic fw_wr;
  logic fw_rd;
  logic main_up;
  logic main_rst;
  logic long_sel;
  logic [7:0] rd_val;
  logic zw_hit;

  assign off = xaddr_i[7:0];
  assign fw_hit = (xaddr_i[15:8] == `EC_PAGE);
  assign fw_wr = xwr_i & fw_hit;
  assign fw_rd = xrd_i & fw_hit;
  assign main_up = main_valid_i & power_good_input_i;
  assign long_sel = clock_normal_mode_i & clock_valid_time_bit_i;
  // at or past the bound, so a switch from long to short wait still ends
  assign main_rst = (s_q.seq == MP_WAIT) &&
                    (s_q.cnt >= (long_sel ? LONG_LAST : SHORT_LAST));
  assign zw_hit = (sys_index_i == `IDX_PW0) || (sys_index_i == `IDX_PW1);
  assign zero_wait_o = (sys_rd_i | sys_wr_i) & zw_hit;

  // firmware read multiplexer
  always_comb
  begin
    rd_val = 8'h00;
    case (off)
      `OFF_REV: rd_val = REV_CODE;
      `OFF_DEV_ID: rd_val = DEV_CODE;
      `OFF_LED: rd_val = s_q.ctl.led;
      `OFF_PORT_D: rd_val = s_q.ctl.port_d;
      `OFF_PORT_E: rd_val = s_q.ctl.port_e;
      `OFF_PORT_F: rd_val = periph_i.port_f;
      `OFF_PW0: rd_val = s_q.ctl.pw0;
      `OFF_PW1: rd_val = s_q.ctl.pw1;
      `OFF_CLK_CTL: rd_val = s_q.ctl.clk_ctl;
      `OFF_MEM_MAP: rd_val = s_q.ctl.mem_map;
      `OFF_WSRC1: rd_val = periph_i.wsrc1;
      `OFF_WSRC2: rd_val = periph_i.wsrc2;
      `OFF_WMASK1: rd_val = s_q.ctl.wmask1;
      `OFF_WMASK2: rd_val = s_q.ctl.wmask2;
      `OFF_PSEL3: rd_val = s_q.ctl.psel3;
      `OFF_TW_CTL_STAT: rd_val = periph_i.tw_stat;
      `OFF_TW_ADDR: rd_val = s_q.ctl.tw_addr;
      `OFF_TW_DATA: rd_val = s_q.ctl.tw_data;
      `OFF_TW_CLK: rd_val = s_q.ctl.tw_clk;
      `OFF_WSRC3: rd_val = periph_i.wsrc3;
      `OFF_WMASK3: rd_val = s_q.ctl.wmask3;
      `OFF_WDT_CTL: rd_val = s_q.ctl.wdt_ctl;
      `OFF_WDT_CNT: rd_val = s_q.ctl.wdt_cnt;
      `OFF_PP_STAT: rd_val = s_q.ctl.pp_stat;
      `OFF_PP_CTL: rd_val = s_q.ctl.pp_ctl;
      `OFF_PP_DATA: rd_val = s_q.ctl.pp_data;
      `OFF_PSEL1: rd_val = s_q.ctl.psel1;
      // power good is a live read-only view, never stored
      `OFF_OUT_EN: rd_val = s_q.ctl.out_en |
                            {5'h00, power_good_input_i, 2'h0};
      `OFF_DISABLE: rd_val = s_q.ctl.func_dis;
      `OFF_PSEL2: rd_val = s_q.ctl.psel2;
      `OFF_PS2A_CTL: rd_val = s_q.ctl.ps2a_ctl;
      `OFF_PS2A_STAT: rd_val = periph_i.ps2a_stat;
      `OFF_PS2A_ERR: rd_val = periph_i.ps2a_err;
      `OFF_PS2A_RX: rd_val = periph_i.ps2a_rx;
      `OFF_PS2B_CTL: rd_val = s_q.ctl.ps2b_ctl;
      `OFF_PS2B_STAT: rd_val = periph_i.ps2b_stat;
      `OFF_PS2B_ERR: rd_val = periph_i.ps2b_err;
      `OFF_PS2B_RX: rd_val = periph_i.ps2b_rx;
      `OFF_KBD_DATA: rd_val = s_q.in_data;
      `OFF_KBD_STAT: rd_val = s_q.kbd_stat;
      `OFF_KBD_CFG: rd_val = s_q.ctl.kbd_cfg;
      default: rd_val = 8'h00;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    s_d.xrdata = fw_rd ? rd_val : s_q.xrdata;
    if (fw_wr)
    begin
      case (off)
        `OFF_LED: s_d.ctl.led = xwdata_i;
        `OFF_PORT_D: s_d.ctl.port_d = xwdata_i;
        `OFF_PORT_E: s_d.ctl.port_e = xwdata_i;
        `OFF_PW0: s_d.ctl.pw0 = xwdata_i;
        `OFF_PW1: s_d.ctl.pw1 = xwdata_i;
        `OFF_CLK_CTL: s_d.ctl.clk_ctl = xwdata_i;
        `OFF_MEM_MAP: s_d.ctl.mem_map = xwdata_i;
        `OFF_WMASK1: s_d.ctl.wmask1 = xwdata_i;
        `OFF_WMASK2: s_d.ctl.wmask2 = xwdata_i;
        `OFF_PSEL3: s_d.ctl.psel3 = xwdata_i;
        `OFF_TW_CTL_STAT: s_d.ctl.tw_ctl = xwdata_i;
        `OFF_TW_ADDR: s_d.ctl.tw_addr = xwdata_i;
        `OFF_TW_DATA: s_d.ctl.tw_data = xwdata_i;
        `OFF_TW_CLK: s_d.ctl.tw_clk = xwdata_i;
        `OFF_WMASK3: s_d.ctl.wmask3 = xwdata_i;
        `OFF_WDT_CTL: s_d.ctl.wdt_ctl = xwdata_i;
        `OFF_WDT_CNT: s_d.ctl.wdt_cnt = xwdata_i;
        `OFF_PP_STAT: s_d.ctl.pp_stat =
          (s_q.ctl.pp_stat & ~`PP_STAT_WR_MASK) |
          (xwdata_i & `PP_STAT_WR_MASK);
        `OFF_PP_CTL: s_d.ctl.pp_ctl = xwdata_i;
        `OFF_PP_DATA: s_d.ctl.pp_data = xwdata_i;
        `OFF_PSEL1: s_d.ctl.psel1 = xwdata_i;
        `OFF_OUT_EN:
        begin
          s_d.ctl.out_en = xwdata_i & `OE_WR_MASK;
          if (!power_good_input_i)
            s_d.ctl.out_en[`OE_IRO_BIT] = 1'b1;
          // the override bit lets firmware release reset quietly
          if (s_q.ctl.out_en[`OE_IRO_BIT] && !xwdata_i[`OE_IRO_BIT] &&
              power_good_input_i && !s_q.ctl.out_en[`OE_OVRD_BIT])
          begin
            s_d.ctl.clk_ctl[0] = 1'b1;
            s_d.ctl.mem_map[1:0] = 2'h3;
          end
        end
        `OFF_DISABLE: s_d.ctl.func_dis = xwdata_i;
        `OFF_PSEL2: s_d.ctl.psel2 = xwdata_i;
        `OFF_PS2A_CTL: s_d.ctl.ps2a_ctl = xwdata_i;
        `OFF_PS2A_TX: s_d.ctl.ps2a_tx = xwdata_i;
        `OFF_PS2B_CTL: s_d.ctl.ps2b_ctl = xwdata_i;
        `OFF_PS2B_TX: s_d.ctl.ps2b_tx = xwdata_i;
        `OFF_KBD_CFG: s_d.ctl.kbd_cfg = xwdata_i;
        `OFF_KBD_STAT:
        begin
          // hardware-owned bits keep their value
          if (s_q.ctl.kbd_cfg[`CFG_AUX_HW_BIT])
            s_d.kbd_stat = (s_q.kbd_stat & ~`ST_FW_MASK) |
                           (xwdata_i & `ST_FW_MASK);
          else
          begin
            s_d.kbd_stat = (s_q.kbd_stat & ~`ST_FW_MASK) |
                           (xwdata_i & `ST_FW_MASK);
            s_d.kbd_stat[`ST_AUX_FULL] = xwdata_i[`ST_AUX_FULL];
          end
        end
        default: s_d.xrdata = s_d.xrdata;
      endcase
    end
    if (sys_wr_i && sys_index_i == `IDX_PW0)
      s_d.ctl.pw0 = sys_wdata_i;
    if (sys_wr_i && sys_index_i == `IDX_PW1)
      s_d.ctl.pw1 = sys_wdata_i;
    s_d.sys_rdata = s_q.sys_rdata;
    if (sys_rd_i && sys_index_i == `IDX_PW0)
      s_d.sys_rdata = s_q.ctl.pw0;
    if (sys_rd_i && sys_index_i == `IDX_PW1)
      s_d.sys_rdata = s_q.ctl.pw1;
    // clears first so that a same-cycle set wins
    if (fw_rd && off == `OFF_KBD_DATA)
      s_d.kbd_stat[`ST_IN_FULL] = 1'b0;
    if (host_rd_i)
    begin
      s_d.kbd_stat[`ST_PRI_FULL] = 1'b0;
      s_d.kbd_stat[`ST_AUX_FULL] = 1'b0;
    end
    if (host_wr_i)
    begin
      s_d.in_data = host_wdata_i;
      s_d.kbd_stat[`ST_IN_FULL] = 1'b1;
      s_d.kbd_stat[`ST_CMD] = host_cmd_i;
    end
    if (fw_wr && off == `OFF_KBD_DATA)
    begin
      s_d.out_data = xwdata_i;
      s_d.kbd_stat[`ST_PRI_FULL] = 1'b1;
    end
    if (fw_wr && off == `OFF_KBD_AUX)
    begin
      s_d.out_data = xwdata_i;
      if (s_q.ctl.kbd_cfg[`CFG_AUX_HW_BIT])
        s_d.kbd_stat[`ST_AUX_FULL] = 1'b1;
    end
    if (!power_good_input_i)
      s_d.ctl.out_en[`OE_IRO_BIT] = 1'b1;
    // main-plane power-up sequencer
    unique case (s_q.seq)
      MP_OFF:
      begin
        s_d.cnt = 17'h00000;
        if (main_up)
          s_d.seq = MP_WAIT;
      end
      MP_WAIT:
      begin
        s_d.cnt = s_q.cnt + 17'h00001;
        if (!main_up)
          s_d.seq = MP_OFF;
        else if (main_rst)
          s_d.seq = MP_ON;
      end
      MP_ON:
      begin
        s_d.cnt = 17'h00000;
        if (!main_up)
          s_d.seq = MP_OFF;
      end
    endcase
    if (main_up && main_rst)
    begin
      s_d.ctl.port_d = `RST_PORT_D;
      s_d.ctl.port_e = `RST_PORT_E;
      s_d.ctl.pp_stat = 8'h00;
      s_d.ctl.pp_ctl = 8'h00;
      s_d.ctl.pp_data = 8'h00;
      s_d.ctl.ps2a_ctl = 8'h00;
      s_d.ctl.ps2a_tx = 8'h00;
      s_d.ctl.ps2b_ctl = 8'h00;
      s_d.ctl.ps2b_tx = 8'h00;
      s_d.ctl.out_en = {6'h00, 1'b1, s_q.ctl.out_en[0]};
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      s_q <= '{ctl: CTL_INIT, seq: MP_OFF, default: '0};
    else
      s_q <= s_d;
  end

  assign xrdata_o = s_q.xrdata;
  assign sys_rdata_o = s_q.sys_rdata;
  assign host_rdata_o = s_q.out_data;
  assign host_status_o = s_q.kbd_stat;
  assign kbd_irq_o = s_q.ctl.kbd_cfg[`CFG_OBF_EN_BIT] &
                     s_q.kbd_stat[`ST_PRI_FULL];
  assign aux_irq_o = s_q.ctl.kbd_cfg[`CFG_OBF_EN_BIT] &
                     s_q.kbd_stat[`ST_AUX_FULL];
  assign regs_o = s_q.ctl;
  assign main_plane_ready_o = (s_q.seq == MP_ON);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  property p_data_write;
    fw_wr && off == `OFF_KBD_DATA |=> host_rdata_o == $past(xwdata_i);
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("output data not loaded");

  property p_stat_protect;
    fw_wr && off == `OFF_KBD_STAT && !host_wr_i && !host_rd_i
      |=> $stable({host_status_o[3], host_status_o[1:0]});
  endproperty
  a_stat_protect: assert property (p_stat_protect)
    else $error("hardware status bit written by firmware");

  property p_aux_write;
    fw_wr && off == `OFF_KBD_AUX && !host_rd_i &&
      s_q.ctl.kbd_cfg[`CFG_AUX_HW_BIT]
      |=> host_status_o[`ST_AUX_FULL] && $stable(host_status_o[0]);
  endproperty
  a_aux_write: assert property (p_aux_write)
    else $error("aux write flag behaviour wrong");

  property p_fw_clear;
    fw_rd && off == `OFF_KBD_DATA && !host_wr_i
      |=> !host_status_o[`ST_IN_FULL];
  endproperty
  a_fw_clear: assert property (p_fw_clear)
    else $error("input full not cleared by firmware read");

  property p_host_clear;
    host_rd_i && !fw_wr |=> !host_status_o[`ST_PRI_FULL] && !kbd_irq_o;
  endproperty
  a_host_clear: assert property (p_host_clear)
    else $error("output full not cleared by host read");

  property p_zero_wait;
    sys_rd_i && sys_index_i == `IDX_PW0
      |-> zero_wait_o ##1 sys_rdata_o == regs_o.pw0;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("pulse width system read wrong");

  property p_pp_stat;
    fw_wr && off == `OFF_PP_STAT && !main_rst
      |=> regs_o.pp_stat[7:1] == $past(regs_o.pp_stat[7:1]);
  endproperty
  a_pp_stat: assert property (p_pp_stat)
    else $error("parallel status upper bit changed");

  property p_iro_clear;
    fw_wr && off == `OFF_OUT_EN && regs_o.out_en[1] && !xwdata_i[1] &&
      !regs_o.out_en[3] && power_good_input_i
      |=> regs_o.clk_ctl[0] && regs_o.mem_map[1:0] == 2'h3;
  endproperty
  a_iro_clear: assert property (p_iro_clear)
    else $error("reset-out clear side effects missing");

  property p_pg_hold;
    !power_good_input_i |=> regs_o.out_en[`OE_IRO_BIT];
  endproperty
  a_pg_hold: assert property (p_pg_hold)
    else $error("reset-out cleared without power good");

  property p_short_wait;
    s_q.seq == MP_WAIT && main_up && !long_sel
      |=> main_plane_ready_o ||
          (s_q.cnt <= SHORT_LAST && s_q.cnt == $past(s_q.cnt) + 17'h00001);
  endproperty
  a_short_wait: assert property (p_short_wait)
    else $error("main plane not reset in time");

  property p_reserved;
    fw_rd && off == 8'h46 |=> xrdata_o == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved offset reads nonzero");

  property p_rev;
    fw_rd && off == `OFF_REV |=> xrdata_o == REV_CODE;
  endproperty
  a_rev: assert property (p_rev)
    else $error("revision read wrong");

  c_main_ready: cover property (main_rst);
  c_aux_set: cover property (fw_wr && off == `OFF_KBD_AUX ##1 aux_irq_o);
  c_set_wins: cover property (host_rd_i && fw_wr && off == `OFF_KBD_DATA);
  c_iro_clear: cover property (fw_wr && off == `OFF_OUT_EN &&
                               regs_o.out_en[1] && !xwdata_i[1]);

endmodule : embedded_controller_register_map

// >>> testbench/fw_core_model.sv
// behavioural firmware core that drives the bank's data-space bus
`timescale 1ns/1ps

module fw_core_model (
  input wire logic ref_clk_i,
  output logic [15:0] xaddr_o,
  output logic xrd_o,
  output logic xwr_o,
  output logic [7:0] xwdata_o
);
  initial
  begin
    xaddr_o = 16'h0000;
    xrd_o = 1'b0;
    xwr_o = 1'b0;
    xwdata_o = 8'h00;
  end

  // gap cycles model a slow core, no gap a prompt one
  task automatic xfer(input logic wr, input logic [15:0] a,
                      input logic [7:0] d, input int gap);
    repeat (gap) @(posedge ref_clk_i);
    @(posedge ref_clk_i);
    #1;
    xaddr_o = a;
    xwdata_o = d;
    xwr_o = wr;
    xrd_o = !wr;
    @(posedge ref_clk_i);
    #1;
    xwr_o = 1'b0;
    xrd_o = 1'b0;
    // released lines show the inverse so a stale value cannot match
    xaddr_o = ~a;
    xwdata_o = ~d;
  endtask : xfer
endmodule : fw_core_model

// >>> testbench/tb.sv
// self-checking bench for the embedded controller register bank
`timescale 1ns/1ps
`include "ec_regs_cfg.svh"

module tb;
  import ec_regs_pkg::*;
  localparam int LONG = 20;
  localparam logic [7:0] REV = 8'h3C; // arbitrary value
  localparam logic [7:0] DEV = 8'hA5; // arbitrary value
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] xaddr;
  logic xrd;
  logic xwr;
  logic [7:0] xwdata;
  logic [7:0] xrdata;
  logic [7:0] sys_index = 8'h00;
  logic sys_rd = 1'b0;
  logic sys_wr = 1'b0;
  logic [7:0] sys_wdata = 8'h00;
  logic [7:0] sys_rdata;
  logic zero_wait;
  logic host_wr = 1'b0;
  logic host_cmd = 1'b0;
  logic [7:0] host_wdata = 8'h00;
  logic host_rd = 1'b0;
  logic [7:0] host_rdata;
  logic [7:0] host_status;
  logic kbd_irq;
  logic aux_irq;
  logic main_valid = 1'b0;
  logic pg = 1'b0;
  logic normal = 1'b0;
  logic valid_time = 1'b0;
  periph_stat_s periph = '0;
  ctrl_regs_s regs;
  logic ready;
  int errors = 0;
  int comparisons = 0;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [7:0] v;
  logic c;
  int n;

  initial
  begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  fw_core_model fw (
    .ref_clk_i(ref_clk_i),
    .xaddr_o(xaddr),
    .xrd_o(xrd),
    .xwr_o(xwr),
    .xwdata_o(xwdata)
  );

  embedded_controller_register_map #(
    .MAIN_LONG_CYC(LONG),
    .REV_CODE(REV),
    .DEV_CODE(DEV)
  ) uut (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .xaddr_i(xaddr),
    .xrd_i(xrd),
    .xwr_i(xwr),
    .xwdata_i(xwdata),
    .xrdata_o(xrdata),
    .sys_index_i(sys_index),
    .sys_rd_i(sys_rd),
    .sys_wr_i(sys_wr),
    .sys_wdata_i(sys_wdata),
    .sys_rdata_o(sys_rdata),
    .zero_wait_o(zero_wait),
    .host_wr_i(host_wr),
    .host_cmd_i(host_cmd),
    .host_wdata_i(host_wdata),
    .host_rd_i(host_rd),
    .host_rdata_o(host_rdata),
    .host_status_o(host_status),
    .kbd_irq_o(kbd_irq),
    .aux_irq_o(aux_irq),
    .main_valid_i(main_valid),
    .power_good_input_i(pg),
    .clock_normal_mode_i(normal),
    .clock_valid_time_bit_i(valid_time),
    .periph_i(periph),
    .regs_o(regs),
    .main_plane_ready_o(ready)
  );

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic conclude();
    repeat (3) @(posedge ref_clk_i);
    errors += exp_q.size();
    $display("checks %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // read data answers one cycle after the taking edge
  always @(posedge ref_clk_i)
  begin
    if (rd_seen && exp_q.size() > 0)
      chk("xrdata", exp_q.pop_front(), xrdata);
    rd_seen <= xrd && xaddr[15:8] == `EC_PAGE;
  end

  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    fw.xfer(1'b1, {`EC_PAGE, off}, d, $urandom_range(1));
  endtask : wr

  task automatic rd(input logic [7:0] off, input logic [7:0] e);
    exp_q.push_back(e);
    fw.xfer(1'b0, {`EC_PAGE, off}, 8'h00, $urandom_range(1));
  endtask : rd

  task automatic host(input logic w, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    host_wr = w;
    host_rd = !w;
    host_wdata = d;
    @(posedge ref_clk_i);
    #1;
    host_wr = 1'b0;
    host_rd = 1'b0;
  endtask : host

  task automatic sys(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    sys_index = idx;
    sys_wr = w;
    sys_rd = !w;
    sys_wdata = d;
    #1;
    chk("zero_wait", {7'h00, idx[7:1] == 7'h49}, {7'h00, zero_wait});
    @(posedge ref_clk_i);
    #1;
    sys_wr = 1'b0;
    sys_rd = 1'b0;
  endtask : sys

  task automatic wait_ready(input int lo, input int hi);
    n = 0;
    while (ready !== 1'b1 && n <= hi)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    comparisons++;
    if (n < lo || n > hi)
    begin
      errors++;
      $display("Error ready_cycles expected %0d..%0d seen %0d", lo, hi, n);
    end
    if (n > hi)
      conclude();
  endtask : wait_ready

  initial
  begin
    v = 8'($urandom(2846));
    periph = periph_stat_s'(88'({$urandom, $urandom, $urandom}));
    repeat (3) @(posedge ref_clk_i);
    #1;
    reset_i = 1'b0;
    rd(8'h27, 8'h10);
    rd(8'h36, 8'hFF);
    rd(8'h38, 8'hFF);
    rd(8'h3E, 8'h02);
    rd(8'h06, REV);
    rd(8'h07, DEV);
    rd(8'h46, 8'h00);
    rd(8'h44, 8'h00);
    rd(8'h22, 8'h00);
    $display("test reset values done");
    v = 8'($urandom);
    wr(8'h25, v);
    fw.xfer(1'b1, 16'h7E25, ~v, 0);
    rd(8'h25, v);
    sys(1'b0, 8'h92, 8'h00);
    chk("sys_rdata", v, sys_rdata);
    sys(1'b1, 8'h93, ~v);
    sys(1'b1, 8'h94, v);
    rd(8'h26, ~v);
    wr(8'h3A, 8'hFF);
    rd(8'h3A, 8'h01);
    wr(8'h46, 8'hFF);
    rd(8'h46, 8'h00);
    wr(8'h31, v);
    chk("twowire_control", v, regs.tw_ctl);
    rd(8'h31, periph.tw_stat);
    $display("test register access done");
    c = 1'($urandom_range(1));
    host_cmd = c;
    wr(8'hF4, 8'h20);
    wr(8'hF1, v);
    chk("host_status", 8'h01, host_status);
    chk("host_data", v, host_rdata);
    chk("kbd_irq", 8'h01, {7'h00, kbd_irq});
    host(1'b0, 8'h00);
    chk("host_status", 8'h00, host_status);
    host(1'b1, ~v);
    chk("host_status", {4'h0, c, 3'h2}, host_status);
    rd(8'hF1, ~v);
    chk("host_status", {4'h0, c, 3'h0}, host_status);
    wr(8'hF2, 8'hFF);
    chk("host_status", {4'hF, c, 3'h4}, host_status);
    wr(8'hF2, 8'h00);
    wr(8'hF4, 8'hA0);
    wr(8'hFA, v);
    chk("host_status", {4'h2, c, 3'h0}, host_status);
    chk("host_data", v, host_rdata);
    chk("irq_pair", 8'h01, {6'h00, kbd_irq, aux_irq});
    host(1'b0, 8'h00);
    chk("host_status", {4'h0, c, 3'h0}, host_status);
    $display("test mailbox done");
    wr(8'h3E, 8'h00);
    rd(8'h3E, 8'h02);
    pg = 1'b1;
    wr(8'h3E, 8'h01);
    rd(8'h3E, 8'h05);
    chk("core_clock_control", 8'h11, regs.clk_ctl);
    chk("core_memory_map", 8'h03, regs.mem_map);
    wr(8'h27, 8'h00);
    wr(8'h29, 8'h00);
    wr(8'h3E, 8'h0B);
    wr(8'h3E, 8'h09);
    chk("core_clock_control", 8'h00, regs.clk_ctl);
    chk("core_memory_map", 8'h00, regs.mem_map);
    rd(8'h3E, 8'h0D);
    $display("test reset out done");
    rd(8'h23, 8'h00);
    normal = 1'b1;
    valid_time = 1'b1;
    main_valid = 1'b1;
    wait_ready(LONG, 2 * LONG + 2);
    rd(8'h22, 8'hFF);
    rd(8'h23, 8'h0F);
    rd(8'h3A, 8'h00);
    rd(8'h3E, 8'h07);
    wr(8'h22, 8'h00);
    wr(8'h3E, 8'h00);
    main_valid = 1'b0;
    normal = 1'b0;
    @(posedge ref_clk_i);
    #1;
    main_valid = 1'b1;
    repeat (`MAIN_SHORT_CYC + 2) @(posedge ref_clk_i);
    rd(8'h22, 8'hFF);
    rd(8'h3E, 8'h06);
    $display("test main plane reset done");
    conclude();
  end
endmodule : tb
